/* shared/gisw_consts.vh */
`ifndef GISW_CONSTS_VH
`define GISW_CONSTS_VH
// Register byte addresses.
`define GISW_ADDR_EDGE_ROW_LO 8'hD0
`define GISW_ADDR_EDGE_ROW_HI 8'hD1
`define GISW_ADDR_IE_COL 8'hD2
`define GISW_ADDR_IE_ROW_LO 8'hD3
`define GISW_ADDR_IE_ROW_HI 8'hD4
`define GISW_ADDR_RAW_COL 8'hD6
`define GISW_ADDR_RAW_ROW_LO 8'hD7
`define GISW_ADDR_RAW_ROW_HI 8'hD8
`define GISW_ADDR_MIS_COL 8'hD9
`define GISW_ADDR_MIS_ROW_LO 8'hDA
`define GISW_ADDR_MIS_ROW_HI 8'hDB
`define GISW_ADDR_CLR_COL 8'hDC
`define GISW_ADDR_CLR_ROW_LO 8'hDD
`define GISW_ADDR_CLR_ROW_HI 8'hDE
`define GISW_ADDR_WAKE_COL 8'hE9
`define GISW_ADDR_WAKE_ROW_LO 8'hEA
`define GISW_ADDR_WAKE_ROW_HI 8'hEB
// Reset values.
`define GISW_RST_ZERO8 8'h00
`define GISW_RST_EDGE8 8'hFF
// Row polarity bits reset high; column bits reset low and stay low-active.
`define GISW_RST_POL20 20'hFFF00
`define GISW_RST_ZERO20 20'h00000
// Field positions in the flat 20-pin vectors: columns 7:0, rows 19:8.
`define GISW_COL_LSB 0
`define GISW_ROW_LSB 8
`define GISW_ROWHI_LSB 16
`define GISW_HI_W 4
`endif

/* hdl/gisw_irq_status_wake.v */
`timescale 1ns/1ps
`include "gisw_consts.vh"
// Overview of operation
// - Raw (latched, unmasked) interrupt status of row pins 8..11 reads in bits 3:0 of byte D8.
// - Masked status of column pins 0..7 reads in byte D9.
// - Masked status of row pins 0..7 reads in byte DA, one bit per pin.
// - Masked status of row pins 8..11 in DB bits 3:0; upper bits reserved.
// - A set wake bit lets its pin's activity end sleep; clear bit blocks it.
// - Column wake enable byte E9, bit n is column pin n, resets zero.
// - Row low wake enable byte EA, bit n is row pin n, resets zero.
// - Row high wake enable byte EB, bit 3 is pin 11, upper bits reserved.
// - Raw and masked status read zero after reset and ignore writes.
// - Per-pin interrupt enable bit, reset zero, one allows the interrupt.
// - Writing one to a clear bit clears that pending interrupt unless its pin's trigger is active in that cycle; zero no effect.
// - Per-pin polarity bit: zero low level, one high level; level sensitive, not edge.
module gisw_irq_status_wake #(
  parameter NUM_PINS = 20
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Register access port from the serial slave.
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata_ff,
  // Pin levels, columns in 7:0 and rows 0..11 in 19:8.
  input wire [NUM_PINS-1:0] pinLevel,
  // Sleep control.
  input wire sleeping,
  output reg wakeReq_ff,
  output reg irqReq_ff
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [NUM_PINS-1:0] polarity_ff;
  reg [NUM_PINS-1:0] irqAllow_ff;
  reg [NUM_PINS-1:0] wakeBit_ff;
  reg [NUM_PINS-1:0] rawFlag_ff;
  reg [NUM_PINS-1:0] pinPrev_ff;
  reg [NUM_PINS-1:0] clrMask;
  reg [NUM_PINS-1:0] nxt_rawFlag;
  reg [7:0] nxt_regRdata;
  wire [NUM_PINS-1:0] maskedFlag;
  wire [NUM_PINS-1:0] trigger;
  wire [NUM_PINS-1:0] activity;
  wire [7:0] hiPad;

  assign hiPad = `GISW_RST_ZERO8;

  // ****************************************************************
  // Per-pin trigger, masking and activity
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : gPin
      // Active level of the selected polarity; level sensitive, no edge detect.
      assign trigger[gi] = polarity_ff[gi] ? pinLevel[gi] : ~pinLevel[gi];
      assign maskedFlag[gi] = rawFlag_ff[gi] & irqAllow_ff[gi];
      assign activity[gi] = (pinLevel[gi] ^ pinPrev_ff[gi]) & wakeBit_ff[gi];
    end
  endgenerate

  // ****************************************************************
  // Clear decode
  // ****************************************************************
  // Writes of one to a clear byte select the pending flags to drop.
  always @* begin
    clrMask = `GISW_RST_ZERO20;
    if (regWrite) begin
      case (regAddr)
        `GISW_ADDR_CLR_COL: clrMask[`GISW_ROW_LSB-1:`GISW_COL_LSB] = regWdata;
        `GISW_ADDR_CLR_ROW_LO: clrMask[`GISW_ROWHI_LSB-1:`GISW_ROW_LSB] = regWdata;
        `GISW_ADDR_CLR_ROW_HI: begin
          clrMask[NUM_PINS-1:`GISW_ROWHI_LSB] = regWdata[`GISW_HI_W-1:0];
        end
        default: clrMask = `GISW_RST_ZERO20;
      endcase
    end
  end

  // A trigger in the clearing cycle keeps the flag set.
  always @* begin
    nxt_rawFlag = (rawFlag_ff & ~clrMask) | trigger;
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Reserved bits and unmapped or write-only addresses read as zero.
  always @* begin
    nxt_regRdata = regRdata_ff;
    if (regRead) begin
      case (regAddr)
        `GISW_ADDR_EDGE_ROW_LO: nxt_regRdata = polarity_ff[15:8];
        `GISW_ADDR_EDGE_ROW_HI: nxt_regRdata = {hiPad[3:0], polarity_ff[19:16]};
        `GISW_ADDR_IE_COL: nxt_regRdata = irqAllow_ff[7:0];
        `GISW_ADDR_IE_ROW_LO: nxt_regRdata = irqAllow_ff[15:8];
        `GISW_ADDR_IE_ROW_HI: nxt_regRdata = {hiPad[3:0], irqAllow_ff[19:16]};
        `GISW_ADDR_RAW_COL: nxt_regRdata = rawFlag_ff[7:0];
        `GISW_ADDR_RAW_ROW_LO: nxt_regRdata = rawFlag_ff[15:8];
        `GISW_ADDR_RAW_ROW_HI: nxt_regRdata = {hiPad[3:0], rawFlag_ff[19:16]};
        `GISW_ADDR_MIS_COL: nxt_regRdata = maskedFlag[7:0];
        `GISW_ADDR_MIS_ROW_LO: nxt_regRdata = maskedFlag[15:8];
        `GISW_ADDR_MIS_ROW_HI: nxt_regRdata = {hiPad[3:0], maskedFlag[19:16]};
        `GISW_ADDR_WAKE_COL: nxt_regRdata = wakeBit_ff[7:0];
        `GISW_ADDR_WAKE_ROW_LO: nxt_regRdata = wakeBit_ff[15:8];
        `GISW_ADDR_WAKE_ROW_HI: nxt_regRdata = {hiPad[3:0], wakeBit_ff[19:16]};
        default: nxt_regRdata = `GISW_RST_ZERO8;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Control bytes take writes; status bytes have no write path.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      polarity_ff <= `GISW_RST_POL20;
      irqAllow_ff <= `GISW_RST_ZERO20;
      wakeBit_ff <= `GISW_RST_ZERO20;
      rawFlag_ff <= `GISW_RST_ZERO20;
      pinPrev_ff <= `GISW_RST_ZERO20;
      regRdata_ff <= `GISW_RST_ZERO8;
      wakeReq_ff <= 1'b0;
      irqReq_ff <= 1'b0;
    end else begin
      rawFlag_ff <= nxt_rawFlag;
      pinPrev_ff <= pinLevel;
      regRdata_ff <= nxt_regRdata;
      wakeReq_ff <= sleeping & (|activity);
      irqReq_ff <= |maskedFlag;
      if (regWrite) begin
        case (regAddr)
          `GISW_ADDR_EDGE_ROW_LO: polarity_ff[15:8] <= regWdata;
          `GISW_ADDR_EDGE_ROW_HI: polarity_ff[19:16] <= regWdata[3:0];
          `GISW_ADDR_IE_COL: irqAllow_ff[7:0] <= regWdata;
          `GISW_ADDR_IE_ROW_LO: irqAllow_ff[15:8] <= regWdata;
          `GISW_ADDR_IE_ROW_HI: irqAllow_ff[19:16] <= regWdata[3:0];
          `GISW_ADDR_WAKE_COL: wakeBit_ff[7:0] <= regWdata;
          `GISW_ADDR_WAKE_ROW_LO: wakeBit_ff[15:8] <= regWdata;
          `GISW_ADDR_WAKE_ROW_HI: wakeBit_ff[19:16] <= regWdata[3:0];
          default: polarity_ff <= polarity_ff;
        endcase
      end
    end
  end

endmodule

/* dv/gisw_irq_status_wake_properties.sv */
`timescale 1ns/1ps
// ***
// Checker
// ***
module gisw_props #(parameter NUM_PINS = 20) (
  // Block ports.
  input wire core_clk, input wire reset_n, input wire regWrite, input wire regRead,
  input wire [7:0] regAddr, input wire [7:0] regWdata, input wire [7:0] regRdata_ff,
  input wire [NUM_PINS-1:0] pinLevel, input wire sleeping, input wire wakeReq_ff,
  input wire irqReq_ff);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Port relations.
  wake_sleep_a: assert property (wakeReq_ff |-> $past(sleeping)) else $error("wake");
  wake_edge_a: assert property (wakeReq_ff |-> $past(pinLevel) != $past(pinLevel, 2))
    else $error("edge");
  unmapped_read_a: assert property (regRead && regAddr inside {[8'hDC:8'hE8]} |=> !regRdata_ff)
    else $error("unmapped");
  reserved_bits_a: assert property (regRead && regAddr inside {8'hD8, 8'hDB, 8'hEB}
    |=> !regRdata_ff[7:4]) else $error("reserved");
  read_hold_a: assert property (!regRead |=> $stable(regRdata_ff)) else $error("hold");
  wake_readback_a: assert property (regWrite ##1 (regRead && regAddr == $past(regAddr)
    && regAddr inside {8'hE9, 8'hEA}) |=> regRdata_ff == $past(regWdata, 2)) else $error("wb");
  mask_irq_a: assert property (regRead && regAddr inside {8'hD9, 8'hDA, 8'hDB}
    |=> !regRdata_ff || irqReq_ff) else $error("irq");
  reset_quiet_a: assert property (!$past(reset_n) |-> !irqReq_ff && !wakeReq_ff)
    else $error("quiet");
  // Main scenarios.
  cover property (wakeReq_ff);
  cover property (irqReq_ff);
  cover property (regWrite && regAddr == 8'hEB);
endmodule
bind gisw_irq_status_wake gisw_props #(.NUM_PINS(NUM_PINS)) chk_u (.*);

/* dv/gisw_host_model.sv */
`timescale 1ns/1ps
// ***
// Host
// ***
module gisw_host_model (
  // Register port.
  input wire core_clk, output logic regWrite = 1'h0, output logic regRead = 1'h0,
  output logic [7:0] regAddr = 8'h00, output logic [7:0] regWdata = 8'h00);
  // Sets a request at the fall; the block takes it at the next rise.
  task acc(logic w, r, logic [7:0] a, d);
    @(negedge core_clk);
    {regWrite, regRead, regAddr, regWdata} = {w, r, a, d};
  endtask
  // Release; lines stop showing the last value.
  task idle();
    acc(1'h0, 1'h0, ~regAddr, ~regWdata);
  endtask
endmodule

/* dv/gisw_irq_status_wake_test.sv */
`timescale 1ns/1ps
// ***
// Bench
// ***
module gisw_irq_status_wake_test;
  logic core_clk = 1'h0, reset_n = 1'h0, sleeping = 1'h0, regWrite, regRead, wakeReq_ff;
  logic irqReq_ff;
  logic [7:0] regAddr, regWdata, regRdata_ff, v;
  logic [19:0] pinLevel = 20'h000FF;
  int errCount = 0, nChecks = 0, i, k;
  // Clock, host and block.
  always #50 core_clk = ~core_clk;
  gisw_host_model host_u (.*);
  gisw_irq_status_wake dut_u (.*);
  // Wake byte readback value.
  function automatic logic [7:0] wakeExp(int a, logic [7:0] d);
    return (a == 'hEB) ? (d & 8'h0F) : d;
  endfunction
  // Compares and counts.
  task chk(string n, logic [7:0] e, g);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Reads a byte and compares it.
  task rdChk(int a, logic [7:0] e);
    host_u.acc(1'h0, 1'h1, 8'(a), 8'h00);
    host_u.idle();
    chk("read", e, regRdata_ff);
  endtask
  // Counts, verdict and end.
  task completeRun();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence.
  initial begin
    v = 8'($urandom(44400));
    repeat (6) @(negedge core_clk);
    reset_n = 1'h1;
    for (i = 'hD2; i < 'hEC; i++) rdChk(i, 8'h00);
    for (i = 'hE9; i < 'hEC; i++) begin
      v = 8'($urandom);
      host_u.acc(1'h1, 1'h0, 8'(i), v);
      rdChk(i, wakeExp(i, v));
    end
    host_u.acc(1'h1, 1'h0, 8'hDB, v);
    rdChk('hDB, 8'h00);
    $display("test 1 end");
    v = 8'($urandom) & 8'h0F | 8'h01;
    pinLevel[19:16] = v[3:0];
    rdChk('hD8, v);
    host_u.acc(1'h1, 1'h0, 8'hD4, 8'hFF);
    rdChk('hDB, v);
    chk("irq", 8'h01, {7'h00, irqReq_ff});
    pinLevel[19:16] = 4'h0;
    host_u.acc(1'h1, 1'h0, 8'hDE, 8'h0E);
    rdChk('hD8, 8'h01);
    v = 8'($urandom);
    host_u.acc(1'h1, 1'h0, 8'hD2, v);
    host_u.acc(1'h1, 1'h0, 8'hD3, 8'hFF);
    pinLevel[15:0] = {v, 8'h00};
    rdChk('hD9, v);
    rdChk('hDA, v);
    $display("test 2 end");
    host_u.acc(1'h1, 1'h0, 8'hE9, 8'h01);
    host_u.idle();
    sleeping = 1'h1;
    pinLevel[0] = 1'h1;
    for (k = 0; k < 4 && wakeReq_ff !== 1'h1; k++) @(negedge core_clk);
    chk("wake", 8'h01, {7'h00, wakeReq_ff});
    if (k == 4) completeRun();
    host_u.acc(1'h1, 1'h0, 8'hE9, 8'hFE);
    host_u.idle();
    pinLevel[0] = 1'h0;
    repeat (4) @(negedge core_clk) chk("nowake", 8'h00, {7'h00, wakeReq_ff});
    $display("test 3 end");
    completeRun();
  end
endmodule
